// ==== hw/rtc_pkg.sv ====
package rtc_pkg;
  localparam logic [7:0] RTC_ADDR_RESTART = 8'h04;
  localparam logic [7:0] RTC_ADDR_SEC = 8'h08;
  localparam logic [7:0] RTC_ADDR_MIN = 8'h09;
  localparam logic [7:0] RTC_ADDR_HOUR = 8'h0A;
  localparam logic [7:0] RTC_ADDR_DAY = 8'h0B;
  localparam logic [7:0] RTC_ADDR_WDAY = 8'h0C;
  localparam logic [7:0] RTC_ADDR_MONTH = 8'h0D;
  localparam logic [7:0] RTC_ADDR_YEAR = 8'h0E;
  localparam int RTC_RESTART_BIT = 4;
  localparam int RTC_HOUR_MODE_BIT = 6;
  localparam int RTC_HOUR_PM_BIT = 5;
  localparam logic [7:0] RTC_MASK_SEC = 8'h7F;
  localparam logic [7:0] RTC_MASK_MIN = 8'h7F;
  localparam logic [7:0] RTC_MASK_HOUR = 8'h7F;
  localparam logic [7:0] RTC_MASK_DAY = 8'h3F;
  localparam logic [7:0] RTC_MASK_WDAY = 8'h07;
  localparam logic [7:0] RTC_MASK_MONTH = 8'h1F;
  localparam logic [7:0] RTC_MASK_YEAR = 8'h7F;
  localparam logic [7:0] RTC_RST_SEC = 8'h00;
  localparam logic [7:0] RTC_RST_MIN = 8'h00;
  localparam logic [7:0] RTC_RST_HOUR = 8'h00;
  localparam logic [7:0] RTC_RST_DAY = 8'h01;
  localparam logic [7:0] RTC_RST_WDAY = 8'h01;
  localparam logic [7:0] RTC_RST_MONTH = 8'h01;
  localparam logic [7:0] RTC_RST_YEAR = 8'h00;
  localparam logic [7:0] RTC_MAX_SEC = 8'h59;
  localparam logic [7:0] RTC_MAX_HOUR24 = 8'h23;
  localparam logic [7:0] RTC_HOUR12_ELEVEN = 8'h11;
  localparam logic [7:0] RTC_HOUR12_TWELVE = 8'h12;
  localparam logic [7:0] RTC_MAX_WDAY = 8'h07;
  localparam logic [7:0] RTC_MAX_MONTH = 8'h12;
  localparam logic [7:0] RTC_MAX_YEAR = 8'h79;
  localparam logic [7:0] RTC_FEB = 8'h02;
endpackage

// ==== hw/rtc_time_regs.sv ====
module rtc_time_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic second_tick,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic restart_occurred_flag
);
  import rtc_pkg::*;

  // BCD increment with wrap to a given low value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] max, input logic [7:0] low);
    logic [7:0] r;
    r = v;
    if (v == max) begin
      r = low;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // Last day of a BCD month, February by leap year
  function automatic logic [7:0] month_last(input logic [7:0] mon, input logic leap);
    logic [7:0] r;
    r = 8'h31;
    case (mon)
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      RTC_FEB: r = leap ? 8'h29 : 8'h28;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

  logic [7:0] sec_ff;
  logic [7:0] min_ff;
  logic [7:0] hour_ff;
  logic [7:0] day_ff;
  logic [7:0] wday_ff;
  logic [7:0] month_ff;
  logic [7:0] year_ff;
  logic [7:0] nxt_sec;
  logic [7:0] nxt_min;
  logic [7:0] nxt_hour;
  logic [7:0] nxt_day;
  logic [7:0] nxt_wday;
  logic [7:0] nxt_month;
  logic [7:0] nxt_year;
  logic [7:0] reg_rdata_ff;
  logic [7:0] nxt_rdata;
  logic restart_flag_ff;
  logic nxt_restart_flag;

  wire wr_restart = reg_wr && (reg_addr == RTC_ADDR_RESTART);
  wire soft_restart_request = wr_restart && reg_wdata[RTC_RESTART_BIT];
  wire wr_sec = reg_wr && (reg_addr == RTC_ADDR_SEC);
  wire wr_min = reg_wr && (reg_addr == RTC_ADDR_MIN);
  wire wr_hour = reg_wr && (reg_addr == RTC_ADDR_HOUR);
  wire wr_day = reg_wr && (reg_addr == RTC_ADDR_DAY);
  wire wr_wday = reg_wr && (reg_addr == RTC_ADDR_WDAY);
  wire wr_month = reg_wr && (reg_addr == RTC_ADDR_MONTH);
  wire wr_year = reg_wr && (reg_addr == RTC_ADDR_YEAR);

  // Leap year: BCD year divisible by 4, year 00 included
  wire leap_year = year_ff[4] ? (year_ff[3:0] == 4'h2 || year_ff[3:0] == 4'h6)
                              : (year_ff[3:0] == 4'h0 || year_ff[3:0] == 4'h4 || year_ff[3:0] == 4'h8);
  wire [7:0] day_last = month_last(month_ff, leap_year);

  // Carry chain on each second tick
  wire sec_wrap = (sec_ff == RTC_MAX_SEC);
  wire min_wrap = (min_ff == RTC_MAX_SEC);
  wire mode12 = hour_ff[RTC_HOUR_MODE_BIT];
  wire pm_or_tens_of_hours = hour_ff[RTC_HOUR_PM_BIT];
  wire [7:0] hour12 = {3'b000, hour_ff[4:0]};
  wire [7:0] hour24 = {2'b00, hour_ff[5:0]};
  wire hour_wrap = mode12 ? (hour12 == RTC_HOUR12_ELEVEN && pm_or_tens_of_hours) : (hour24 == RTC_MAX_HOUR24);
  wire day_wrap = (day_ff == day_last);
  wire month_wrap = (month_ff == RTC_MAX_MONTH);

  wire step_sec = second_tick;
  wire step_min = step_sec && sec_wrap;
  wire step_hour = step_min && min_wrap;
  wire step_day = step_hour && hour_wrap;
  wire step_month = step_day && day_wrap;
  wire step_year = step_month && month_wrap;

  wire [7:0] hour12_inc = bcd_inc(hour12, RTC_HOUR12_TWELVE, 8'h01);
  wire [7:0] hour24_inc = bcd_inc(hour24, RTC_MAX_HOUR24, 8'h00);

  logic [7:0] hour_tick;
  always_comb begin
    hour_tick = hour_ff;
    if (mode12) begin
      if (hour12 == RTC_HOUR12_ELEVEN) begin
        hour_tick = {1'b0, 1'b1, ~pm_or_tens_of_hours, RTC_HOUR12_TWELVE[4:0]};
      end else if (hour12 == RTC_HOUR12_TWELVE) begin
        hour_tick = {1'b0, 1'b1, pm_or_tens_of_hours, 5'h01};
      end else begin
        hour_tick = {1'b0, 1'b1, pm_or_tens_of_hours, hour12_inc[4:0]};
      end
    end else begin
      hour_tick = {2'b00, hour24_inc[5:0]};
    end
  end

  // Soft restart wins over a host write, a host write wins over the tick
  assign nxt_sec = soft_restart_request ? RTC_RST_SEC
                 : wr_sec ? (reg_wdata & RTC_MASK_SEC)
                 : step_sec ? bcd_inc(sec_ff, RTC_MAX_SEC, 8'h00) : sec_ff;
  assign nxt_min = soft_restart_request ? RTC_RST_MIN
                 : wr_min ? (reg_wdata & RTC_MASK_MIN)
                 : step_min ? bcd_inc(min_ff, RTC_MAX_SEC, 8'h00) : min_ff;
  assign nxt_hour = soft_restart_request ? RTC_RST_HOUR
                  : wr_hour ? (reg_wdata & RTC_MASK_HOUR)
                  : step_hour ? hour_tick : hour_ff;
  assign nxt_day = soft_restart_request ? RTC_RST_DAY
                 : wr_day ? (reg_wdata & RTC_MASK_DAY)
                 : step_day ? bcd_inc(day_ff, day_last, 8'h01) : day_ff;
  assign nxt_wday = soft_restart_request ? RTC_RST_WDAY
                  : wr_wday ? (reg_wdata & RTC_MASK_WDAY)
                  : step_day ? bcd_inc(wday_ff, RTC_MAX_WDAY, 8'h01) : wday_ff;
  assign nxt_month = soft_restart_request ? RTC_RST_MONTH
                   : wr_month ? (reg_wdata & RTC_MASK_MONTH)
                   : step_month ? bcd_inc(month_ff, RTC_MAX_MONTH, 8'h01) : month_ff;
  assign nxt_year = soft_restart_request ? RTC_RST_YEAR
                  : wr_year ? (reg_wdata & RTC_MASK_YEAR)
                  : step_year ? bcd_inc(year_ff, RTC_MAX_YEAR, 8'h00) : year_ff;
  assign nxt_restart_flag = restart_flag_ff | soft_restart_request;

  // Read mux, unused bits and addresses read 0
  always_comb begin
    nxt_rdata = reg_rdata_ff;
    if (reg_rd) begin
      unique case (reg_addr)
        RTC_ADDR_RESTART: nxt_rdata = 8'h00;
        RTC_ADDR_SEC: nxt_rdata = sec_ff & RTC_MASK_SEC;
        RTC_ADDR_MIN: nxt_rdata = min_ff & RTC_MASK_MIN;
        RTC_ADDR_HOUR: nxt_rdata = hour_ff & RTC_MASK_HOUR;
        RTC_ADDR_DAY: nxt_rdata = day_ff & RTC_MASK_DAY;
        RTC_ADDR_WDAY: nxt_rdata = wday_ff & RTC_MASK_WDAY;
        RTC_ADDR_MONTH: nxt_rdata = month_ff & RTC_MASK_MONTH;
        RTC_ADDR_YEAR: nxt_rdata = year_ff & RTC_MASK_YEAR;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Time registers, one short bank per field
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sec_ff <= RTC_RST_SEC;
    end else begin
      sec_ff <= nxt_sec;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      min_ff <= RTC_RST_MIN;
    end else begin
      min_ff <= nxt_min;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hour_ff <= RTC_RST_HOUR;
    end else begin
      hour_ff <= nxt_hour;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      day_ff <= RTC_RST_DAY;
    end else begin
      day_ff <= nxt_day;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wday_ff <= RTC_RST_WDAY;
    end else begin
      wday_ff <= nxt_wday;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      month_ff <= RTC_RST_MONTH;
    end else begin
      month_ff <= nxt_month;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      year_ff <= RTC_RST_YEAR;
    end else begin
      year_ff <= nxt_year;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_ff <= 8'h00;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      restart_flag_ff <= 1'b0;
    end else begin
      restart_flag_ff <= nxt_restart_flag;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign restart_occurred_flag = restart_flag_ff;
endmodule

// ==== verif/rtc_host.sv ====
module rtc_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic second_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_addr, reg_wdata, reg_wr, reg_rd, second_tick} = 19'h0;
  // Callers only pass legal hours for the chosen format
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic tick();
    @(posedge clk);
    second_tick <= 1'b1;
    @(posedge clk);
    second_tick <= 1'b0;
  endtask
endmodule

// ==== verif/rtc_time_regs_asserts.sv ====
module rtc_time_regs_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic second_tick,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic restart_occurred_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_restart_sets_flag: assert property (reg_wr && reg_addr == 8'h04 && reg_wdata[4] |=> restart_occurred_flag)
    else $error("restart flag not set");
  chk_flag_has_cause: assert property ($rose(restart_occurred_flag) |-> $past(reg_wr) && $past(reg_addr) == 8'h04 && $past(reg_wdata[4]))
    else $error("restart flag rose without request");
  chk_flag_sticky: assert property (restart_occurred_flag |=> restart_occurred_flag)
    else $error("restart flag dropped");
  chk_ctrl_reads_zero: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == 8'h00)
    else $error("restart control read not zero");
  chk_day_top_zero: assert property (reg_rd && reg_addr == 8'h0B |=> reg_rdata[7:6] == 2'h0)
    else $error("day unused bits set");
  chk_sec_bcd_range: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata[7:4] <= 4'h5 && reg_rdata[3:0] <= 4'h9)
    else $error("seconds out of range");
  chk_wday_range: assert property (reg_rd && reg_addr == 8'h0C |=> reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] != 3'h0)
    else $error("weekday out of range");
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
endmodule

bind rtc_time_regs rtc_time_regs_asserts u_chk (.clk(clk), .resetn(resetn), .second_tick(second_tick),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .restart_occurred_flag(restart_occurred_flag));

// ==== verif/rtc_time_regs_tb.sv ====
module rtc_time_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, tick, wr, rd, flag;
  logic [7:0] addr, wdata, rdata, v;
  logic [7:0] h0[4] = '{8'h51, 8'h71, 8'h52, 8'h69};
  logic [7:0] h1[4] = '{8'h72, 8'h52, 8'h41, 8'h70};
  int fail_count, comparisons;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  rtc_host host (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .second_tick(tick));
  rtc_time_regs uut (.clk(clk), .resetn(resetn), .second_tick(tick), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .restart_occurred_flag(flag));
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, v);
    chk($sformatf("reg %h", a), v, exp);
  endtask
  task automatic setc(input logic [7:0] h, input logic [7:0] d, input logic [7:0] m, input logic [7:0] y);
    host.wr(8'h0E, y);
    host.wr(8'h0D, m);
    host.wr(8'h0B, d);
    host.wr(8'h0A, h);
    host.wr(8'h09, 8'h59);
    host.wr(8'h08, 8'h59);
    host.tick();
  endtask
  task automatic complete_run();
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  initial begin
    resetn = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rc(8'h0A, 8'h00);
    rc(8'h0B, 8'h01);
    rc(8'h0C, 8'h01);
    host.wr(8'h08, 8'hD9);
    rc(8'h08, 8'h59);
    host.wr(8'h0C, 8'hF9);
    rc(8'h0C, 8'h01);
    host.wr(8'h05, 8'h33);
    rc(8'h05, 8'h00);
    host.wr(8'h0C, 8'h07);
    setc(8'h23, 8'h28, 8'h02, 8'h01);
    rc(8'h08, 8'h00);
    rc(8'h09, 8'h00);
    rc(8'h0A, 8'h00);
    rc(8'h0B, 8'h01);
    rc(8'h0C, 8'h01);
    rc(8'h0D, 8'h03);
    for (int i = 0; i < 2; i++) begin
      setc(8'h23, 8'h28, 8'h02, 8'(i * 4));
      rc(8'h0B, 8'h29);
    end
    for (int i = 0; i < 4; i++) begin
      setc(h0[i], 8'h05, 8'h01, 8'h01);
      rc(8'h0A, h1[i]);
      rc(8'h0B, (i == 1) ? 8'h06 : 8'h05);
    end
    setc(8'h23, 8'h28, 8'h02, 8'h12);
    rc(8'h0B, 8'h29);
    setc(8'h23, 8'h30, 8'h04, 8'h01);
    rc(8'h0B, 8'h01);
    rc(8'h0D, 8'h05);
    setc(8'h23, 8'h31, 8'h12, 8'h79);
    rc(8'h0B, 8'h01);
    rc(8'h0D, 8'h01);
    rc(8'h0E, 8'h00);
    host.wr(8'h0E, 8'hC5);
    rc(8'h0E, 8'h45);
    host.wr(8'h08, 8'h30);
    host.wr(8'h04, 8'h00);
    rc(8'h08, 8'h30);
    chk("flag", {7'h00, flag}, 8'h00);
    host.wr(8'h04, 8'h10);
    rc(8'h08, 8'h00);
    rc(8'h0A, 8'h00);
    rc(8'h04, 8'h00);
    chk("flag", {7'h00, flag}, 8'h01);
    complete_run();
  end
endmodule
